// >>> design/adcps_sequencer.sv
// Contract
// - Free running: swept channels re-request conversions forever.
// - Channels enter the pipeline one ADC clock apart, after prior sample.
// - Four simultaneous starts are all sampled within four ADC clocks, seven when all are gain channels.
// - 12-bit: first result after seven clocks, rest in following clocks.
// - Up to eight conversions may be in flight together.
// - High impedance keeps hold charge; low impedance discharges on each gain-channel sample.
// - New result raises a DMA request, per channel or grouped.
// - Each channel has its own interrupt enable, mode and line.
// - Interrupt and event on completion, or on above/below compare.
// - Writable linearity calibration register; software loads factory value.
// - Simultaneous starts: lowest-numbered channel is granted first.
// - Gain channel n with plain channel n+1 sample the same instant.
// - In such a pair the gain channel finishes one clock later.
// - Flush discards conversions in flight and restarts the ADC clock divider.
// - Conversions in flight at a flush never deliver a result.
// - Flush comes from software or from a configured event.
// - Pending starts survive a flush; only a grant or reset clears them.
// - Two instances on one event channel start sampling together.
// - Latency is one plus half the resolution, plus one with gain.
// - MSB first, then four or six further clocks by resolution.
// - After a flush, pending work and the sweep resume to completion.
module adcps_sequencer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire adcps_pkg::adcps_codes_t ain,
	input wire logic ev_start,
	output logic [3:0] irq,
	output logic [3:0] ev_out,
	output logic [3:0] dma_req,
	output logic [11:0] cal_value,
	output logic sh_discharge
);

	typedef struct packed {
		adcps_pkg::adcps_cfg_t cfg;
		adcps_pkg::adcps_slot_t [adcps_pkg::NSLOT-1:0] slot;
		logic [3:0] pend;
		logic [3:0] flags;
		logic [3:0] dma;
		logic [3:0] dmaout;
		logic [3:0] irq;
		logic [3:0] evo;
		adcps_pkg::adcps_codes_t res;
		logic blocked;
		logic discharge;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} adcps_top_t;

	adcps_top_t st;
	adcps_top_t next_st;

	logic setup, wr_acc, rd_acc, wr_ctrl, sw_flush, flush_cmd, tick;
	logic addr_hit, rd_res, win_any, grant_any, pair_grant;
	logic [3:0] sw_start, ev_starts, sweep_mask, pend_in, elig, win_hot;
	logic [3:0] set_flags, set_dma, clr_flags, clr_dma;
	logic [1:0] win_idx, pch;
	logic [2:0] f1, f2;
	logic f1_ok, f2_ok, hit;
	logic [3:0] lat;
	logic [7:0] slot_busy;
	logic [31:0] rdval;
	adcps_pkg::adcps_code_t r;

	// ==========================================================
	// Bus decode
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & st.pready & pwrite;
	assign rd_acc = psel & penable & st.pready & ~pwrite;
	assign wr_ctrl = wr_acc && paddr == adcps_pkg::A_CTRL;
	assign addr_hit = paddr == adcps_pkg::A_CTRL ||
		paddr == adcps_pkg::A_CFG || paddr == adcps_pkg::A_EVCTRL ||
		paddr == adcps_pkg::A_CHCFG || paddr == adcps_pkg::A_CMP ||
		paddr == adcps_pkg::A_CAL || paddr == adcps_pkg::A_FLAGS ||
		(paddr >= adcps_pkg::A_RES0 && paddr <= adcps_pkg::A_RES3 &&
		paddr[1:0] == 2'h0);
	assign rd_res = rd_acc && paddr >= adcps_pkg::A_RES0 &&
		paddr <= adcps_pkg::A_RES3 && paddr[1:0] == 2'h0;

	// ==========================================================
	// Start and flush sources
	// starts sampled here
	assign sw_start = wr_ctrl ? pwdata[adcps_pkg::CTRL_START +: 4] : '0;
	assign ev_starts = ev_start ? st.cfg.evmask : '0;
	assign sw_flush = wr_ctrl & pwdata[adcps_pkg::CTRL_FLUSH];
	assign flush_cmd = sw_flush | (ev_start & st.cfg.evflush);

	always_comb begin
		for (int i = 0; i < adcps_pkg::NCH; i++) begin
			sweep_mask[i] = 2'(i) <= st.cfg.sweep;
		end
		for (int i = 0; i < adcps_pkg::NSLOT; i++) begin
			slot_busy[i] = st.slot[i].valid;
		end
	end

	assign pend_in = st.pend | sw_start | ev_starts |
		((flush_cmd & st.cfg.freerun) ? sweep_mask : 4'h0);
	// a start is granted no earlier than the next clock
	assign elig = (st.cfg.enable && tick && !st.blocked && !flush_cmd) ?
		st.pend : 4'h0;

	adcps_prio #(.N(adcps_pkg::NCH)) u_prio (
		.req(elig),
		.hot(win_hot),
		.idx(win_idx),
		.any(win_any)
	);

	adcps_prescaler u_psc (
		.clk(clk),
		.resetn(resetn),
		.enable(st.cfg.enable),
		.restart(flush_cmd),
		.div(st.cfg.div),
		.tick(tick)
	);

	// ==========================================================
	// Read mux
	always_comb begin
		rdval = '0;
		unique case (paddr)
			adcps_pkg::A_CTRL: begin
				rdval[adcps_pkg::CTRL_EN] = st.cfg.enable;
				rdval[adcps_pkg::CTRL_START +: 4] = st.pend;
				rdval[adcps_pkg::CTRL_DMASEL +: 2] = st.cfg.dmasel;
				rdval[adcps_pkg::CTRL_FREE] = st.cfg.freerun;
			end
			adcps_pkg::A_CFG: begin
				rdval[adcps_pkg::CFG_LOWIMP] = st.cfg.lowimp;
				rdval[adcps_pkg::CFG_RES8] = st.cfg.res8;
				rdval[adcps_pkg::CFG_DIV +: 8] = st.cfg.div;
			end
			adcps_pkg::A_EVCTRL: begin
				rdval[adcps_pkg::EV_MASK +: 4] = st.cfg.evmask;
				rdval[adcps_pkg::EV_FLUSH] = st.cfg.evflush;
				rdval[adcps_pkg::EV_SWEEP +: 2] = st.cfg.sweep;
			end
			adcps_pkg::A_CHCFG: begin
				rdval[adcps_pkg::CH_GAIN +: 4] = st.cfg.gain;
				rdval[adcps_pkg::CH_INTEN +: 4] = st.cfg.inten;
				rdval[adcps_pkg::CH_MODE +: 8] = st.cfg.imode;
			end
			adcps_pkg::A_CMP: rdval = 32'(st.cfg.cmp);
			adcps_pkg::A_CAL: rdval = 32'(st.cfg.cal);
			adcps_pkg::A_FLAGS: rdval = 32'(st.flags);
			default: begin
				if (addr_hit) begin
					rdval = 32'(st.res[paddr[adcps_pkg::RES_IDX +: 2]]);
				end
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		grant_any = 1'b0;
		pair_grant = 1'b0;
		set_flags = '0;
		set_dma = '0;
		clr_flags = '0;
		clr_dma = '0;
		f1 = '0;
		f2 = '0;
		f1_ok = 1'b0;
		f2_ok = 1'b0;
		hit = 1'b0;
		lat = '0;
		pch = '0;
		r = '0;
		next_st.pready = setup;
		next_st.pslverr = setup & ~addr_hit;
		next_st.prdata = (setup & ~pwrite) ? rdval : '0;
		next_st.evo = '0;
		next_st.discharge = 1'b0;
		if (wr_acc) begin
			unique case (paddr)
				adcps_pkg::A_CTRL: begin
					next_st.cfg.enable = pwdata[adcps_pkg::CTRL_EN];
					next_st.cfg.dmasel = pwdata[adcps_pkg::CTRL_DMASEL +: 2];
					next_st.cfg.freerun = pwdata[adcps_pkg::CTRL_FREE];
				end
				adcps_pkg::A_CFG: begin
					next_st.cfg.lowimp = pwdata[adcps_pkg::CFG_LOWIMP];
					next_st.cfg.res8 = pwdata[adcps_pkg::CFG_RES8];
					next_st.cfg.div = pwdata[adcps_pkg::CFG_DIV +: 8];
				end
				adcps_pkg::A_EVCTRL: begin
					next_st.cfg.evmask = pwdata[adcps_pkg::EV_MASK +: 4];
					next_st.cfg.evflush = pwdata[adcps_pkg::EV_FLUSH];
					next_st.cfg.sweep = pwdata[adcps_pkg::EV_SWEEP +: 2];
				end
				adcps_pkg::A_CHCFG: begin
					next_st.cfg.gain = pwdata[adcps_pkg::CH_GAIN +: 4];
					next_st.cfg.inten = pwdata[adcps_pkg::CH_INTEN +: 4];
					for (int c = 0; c < adcps_pkg::NCH; c++) begin
						next_st.cfg.imode[c] = adcps_pkg::adcps_imode_t'(
							pwdata[adcps_pkg::CH_MODE + 2 * c +: 2]);
					end
				end
				adcps_pkg::A_CMP: next_st.cfg.cmp = pwdata[11:0];
				adcps_pkg::A_CAL: next_st.cfg.cal = pwdata[11:0];
				adcps_pkg::A_FLAGS: clr_flags = pwdata[3:0];
				default: ;
			endcase
		end
		if (rd_res) begin
			clr_dma[paddr[adcps_pkg::RES_IDX +: 2]] = 1'b1;
		end
		next_st.pend = pend_in;
		if (flush_cmd) begin
			for (int i = 0; i < adcps_pkg::NSLOT; i++) begin
				next_st.slot[i].valid = 1'b0;
			end
			next_st.blocked = 1'b0;
		end else if (tick) begin
			for (int i = 0; i < adcps_pkg::NSLOT; i++) begin
				if (st.slot[i].valid) begin
					if (st.slot[i].cnt == adcps_pkg::CNT_LAST) begin
						next_st.slot[i].valid = 1'b0;
						pch = st.slot[i].ch;
						r = st.cfg.res8 ? adcps_pkg::adcps_code_t'(
							st.slot[i].code[11:adcps_pkg::CODE8_LSB]) :
							st.slot[i].code;
						next_st.res[pch] = r;
						unique case (st.cfg.imode[pch])
							adcps_pkg::IMODE_BELOW: hit = r < st.cfg.cmp;
							adcps_pkg::IMODE_ABOVE: hit = r > st.cfg.cmp;
							adcps_pkg::IMODE_DONE: hit = 1'b1;
							adcps_pkg::IMODE_RSVD: hit = 1'b1;
						endcase
						set_flags[pch] = hit;
						set_dma[pch] = 1'b1;
					end else begin
						next_st.slot[i].cnt = 4'(st.slot[i].cnt - 4'h1);
					end
				end
			end
			for (int i = adcps_pkg::NSLOT - 1; i >= 0; i--) begin
				if (!next_st.slot[i].valid) begin
					f1 = adcps_pkg::SW'(i);
					f1_ok = 1'b1;
				end
			end
			for (int i = adcps_pkg::NSLOT - 1; i >= 0; i--) begin
				if (!next_st.slot[i].valid && adcps_pkg::SW'(i) != f1) begin
					f2 = adcps_pkg::SW'(i);
					f2_ok = 1'b1;
				end
			end
			// gain stage holds the ADC one tick
			if (st.blocked) begin
				next_st.blocked = 1'b0;
			end else if (win_any && f1_ok) begin
				grant_any = 1'b1;
				lat = st.cfg.res8 ? adcps_pkg::LAT_LO : adcps_pkg::LAT_HI;
				next_st.slot[f1].valid = 1'b1;
				next_st.slot[f1].ch = win_idx;
				next_st.slot[f1].code = ain[win_idx];
				next_st.slot[f1].cnt = lat;
				// one winner per tick, two grants with a gain pair; the sweep reloads below
				next_st.pend[win_idx] = 1'b0;
				if (st.cfg.gain[win_idx]) begin
					next_st.slot[f1].cnt = 4'(lat + adcps_pkg::LAT_GAIN);
					next_st.blocked = 1'b1;
					next_st.discharge = st.cfg.lowimp;
					pch = 2'(win_idx + 2'h1);
					if (win_idx != 2'h3 && st.pend[pch] && !st.cfg.gain[pch] &&
						f2_ok) begin
						pair_grant = 1'b1;
						next_st.slot[f2].valid = 1'b1;
						next_st.slot[f2].ch = pch;
						next_st.slot[f2].code = ain[pch];
						next_st.slot[f2].cnt = lat;
						next_st.pend[pch] = 1'b0;
					end
				end
				// free run: a fully served sweep starts over
				// Reloading only when empty keeps high channels from starving
				if (st.cfg.freerun &&
					(next_st.pend & sweep_mask) == 4'h0) begin
					next_st.pend = next_st.pend | sweep_mask;
				end
			end
		end
		// Hardware set wins over a same-cycle clear
		next_st.flags = (st.flags & ~clr_flags) | set_flags;
		next_st.dma = (st.dma & ~clr_dma) | set_dma;
		next_st.evo = set_flags;
		next_st.irq = next_st.flags & next_st.cfg.inten;
		unique case (next_st.cfg.dmasel)
			2'h0: next_st.dmaout = next_st.dma;
			2'h1: next_st.dmaout = {next_st.dma[3:2], 1'h0,
				|next_st.dma[1:0]};
			2'h2: next_st.dmaout = {next_st.dma[3], 2'h0, |next_st.dma[2:0]};
			2'h3: next_st.dmaout = {3'h0, |next_st.dma};
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign ev_out = st.evo;
	assign dma_req = st.dmaout;
	assign cal_value = st.cfg.cal;
	assign sh_discharge = st.discharge;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_flush_aborts: assert property (
		flush_cmd |=> slot_busy == 8'h00)
		else $error("slots survived a flush");
	chk_flush_restart: assert property (
		flush_cmd |=> tick)
		else $error("no ADC strobe right after flush");
	chk_lowest_first: assert property (
		win_any |-> (elig & 4'(win_hot - 4'h1)) == 4'h0)
		else $error("higher channel granted before lower");
	chk_grant_strobe: assert property (
		grant_any |-> tick && st.cfg.enable)
		else $error("grant off the ADC strobe");
	chk_freerun_repend: assert property (
		grant_any && st.cfg.freerun
		|=> (st.pend & $past(sweep_mask)) != 4'h0)
		else $error("free running channel not re-requested");
	chk_gain_block: assert property (
		grant_any && st.cfg.gain[win_idx] |=> st.blocked && !grant_any)
		else $error("gain stage did not hold off next grant");
	chk_irq_gate: assert property (
		$rose(st.flags[0]) && st.cfg.inten[0] |-> st.irq[0])
		else $error("channel interrupt not raised");
	chk_event_tick: assert property (
		|st.evo |-> $past(tick) && !$past(flush_cmd))
		else $error("event outside a strobe");
	chk_discharge_mode: assert property (
		st.discharge |-> st.cfg.lowimp && $past(grant_any))
		else $error("hold discharge in high impedance");
	chk_pair_same: assert property (
		pair_grant |-> grant_any && st.cfg.gain[win_idx])
		else $error("pair grant without gain channel");

	cov_pair: cover property (pair_grant);
	cov_flush_busy: cover property (flush_cmd && |slot_busy);
	cov_freerun_done: cover property (|st.evo && st.cfg.freerun);
	cov_all_start: cover property (pend_in == 4'hf && win_any);

endmodule

// >>> design/adcps_pkg.sv
package adcps_pkg;

	// ==========================================================
	// Sizes
	localparam int NCH = 4;
	localparam int NSLOT = 8;
	localparam int CW = 12;
	localparam int SW = 3;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CFG = 8'h04;
	localparam logic [7:0] A_EVCTRL = 8'h08;
	localparam logic [7:0] A_CHCFG = 8'h0c;
	localparam logic [7:0] A_CMP = 8'h10;
	localparam logic [7:0] A_CAL = 8'h14;
	localparam logic [7:0] A_FLAGS = 8'h18;
	localparam logic [7:0] A_RES0 = 8'h20;
	localparam logic [7:0] A_RES3 = 8'h2c;

	// ==========================================================
	// Field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_FLUSH = 1;
	localparam int CTRL_START = 2;
	localparam int CTRL_DMASEL = 6;
	localparam int CTRL_FREE = 8;
	localparam int CFG_LOWIMP = 0;
	localparam int CFG_RES8 = 1;
	localparam int CFG_DIV = 4;
	localparam int EV_MASK = 0;
	localparam int EV_FLUSH = 4;
	localparam int EV_SWEEP = 5;
	localparam int CH_GAIN = 0;
	localparam int CH_INTEN = 4;
	localparam int CH_MODE = 8;
	localparam int RES_IDX = 2;
	localparam int CODE8_LSB = 4;

	// ==========================================================
	// Timing, in ADC clock ticks
	localparam int RES_HI = 12;
	localparam int RES_LO = 8;
	localparam logic [3:0] LAT_HI = 4'(1 + RES_HI / 2);
	localparam logic [3:0] LAT_LO = 4'(1 + RES_LO / 2);
	localparam logic [3:0] LAT_GAIN = 4'h1;
	localparam logic [3:0] CNT_LAST = 4'h1;

	typedef enum logic [1:0] {
		IMODE_DONE,
		IMODE_BELOW,
		IMODE_ABOVE,
		IMODE_RSVD
	} adcps_imode_t;

	typedef logic [CW-1:0] adcps_code_t;
	typedef adcps_code_t [NCH-1:0] adcps_codes_t;

	typedef struct packed {
		logic enable;
		logic freerun;
		logic [1:0] dmasel;
		logic lowimp;
		logic res8;
		logic [7:0] div;
		logic [NCH-1:0] evmask;
		logic evflush;
		logic [1:0] sweep;
		logic [NCH-1:0] gain;
		logic [NCH-1:0] inten;
		adcps_imode_t [NCH-1:0] imode;
		adcps_code_t cmp;
		adcps_code_t cal;
	} adcps_cfg_t;

	typedef struct packed {
		logic valid;
		logic [1:0] ch;
		logic [3:0] cnt;
		adcps_code_t code;
	} adcps_slot_t;

endpackage

// >>> design/adcps_prescaler.sv
module adcps_prescaler (
	input wire logic clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic restart,
	input wire logic [7:0] div,
	output logic tick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} adcps_psc_t;

	adcps_psc_t st;
	adcps_psc_t next_st;

	// ==========================================================
	// Divider; a restart makes the very next cycle a tick
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (restart) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else if (!enable) begin
			next_st.cnt = '0;
		end else if (st.cnt >= div) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = 8'(st.cnt + 8'h01);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule

// >>> design/adcps_prio.sv
module adcps_prio #(
	parameter int N = 4
) (
	input wire logic [N-1:0] req,
	output logic [N-1:0] hot,
	output logic [$clog2(N)-1:0] idx,
	output logic any
);

	// Lowest index wins
	always_comb begin
		hot = '0;
		idx = '0;
		any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				hot = '0;
				hot[i] = 1'b1;
				idx = ($clog2(N))'(i);
				any = 1'b1;
			end
		end
	end

endmodule

// >>> tb/adcps_far.sv
module adcps_far (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fire,
	output logic ev_start,
	output adcps_pkg::adcps_codes_t ain
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Input stand-in
	// Fixed codes: ch2 sits above a mid-scale threshold, ch0 below it
	assign ain = {12'h3cd, 12'h9ab, 12'h456, 12'h123};

	// ==========================================================
	// Event source
	// pulse lands a clock before the tick, spaced by the bench
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ev_start <= 1'b0;
		else
			ev_start <= fire;
	end
endmodule

// >>> tb/adc_pipeline_sequencer_tb.sv
module adc_pipeline_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, resetn, psel, penable, pwrite, fire;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, ev_start, sh_discharge;
	logic [3:0] irq, ev_out, dma_req;
	logic [11:0] cal_value;
	adcps_pkg::adcps_codes_t ain;
	int mismatches, samples_checked, p0, shd;
	int t[4];

	adcps_sequencer i_dut (
		.clk(clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ain(ain),
		.ev_start(ev_start),
		.irq(irq),
		.ev_out(ev_out),
		.dma_req(dma_req),
		.cal_value(cal_value),
		.sh_discharge(sh_discharge)
	);

	adcps_far i_far (
		.clk(clk),
		.resetn(resetn),
		.fire(fire),
		.ev_start(ev_start),
		.ain(ain)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Cycle of first event per channel, ch0 pulses, discharge pulses
	task automatic watch(input int n);
		t = '{default: 0};
		p0 = 0;
		shd = 0;
		for (int k = 1; k <= n; k++) begin
			@(posedge clk);
			for (int c = 0; c < 4; c++)
				if (ev_out[c] === 1'b1 && t[c] == 0)
					t[c] = k;
			if (ev_out[0] === 1'b1)
				p0++;
			if (sh_discharge === 1'b1)
				shd++;
		end
	endtask

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#100000;
		mismatches++;
		close_out;
	end

	// ==========================================================
	// Tests
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		// Reset values; the last address is unmapped
		for (int a = 0; a < 8; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			check(rd, 32'h0);
			check(32'(err), 32'(a == 7));
		end
		apb(1'b1, adcps_pkg::A_CAL, 32'habc);
		apb(1'b0, adcps_pkg::A_CAL, 32'h0);
		check(rd, 32'habc);
		check(32'(cal_value), 32'habc);
		endt("registers");
		// Run the prescaler first so every start waits the same one clock
		apb(1'b1, 8'h00, 32'h01);
		// Latency by resolution and gain, low impedance discharge
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h04, {30'h0, i[1], 1'b1});
			apb(1'b1, 8'h0c, {31'h0, i[0]});
			apb(1'b1, 8'h00, 32'h05);
			watch(20);
			check(32'(t[0]), 32'((i[1] ? 7 : 9) + i[0]));
			check(32'(shd), 32'(i[0]));
			apb(1'b0, 8'h20, 32'h0);
			check(rd, i[1] ? 32'h12 : 32'h123);
		end
		endt("latency");
		// Four channels started together
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0c, 32'h40);
		apb(1'b1, 8'h18, 32'hf);
		apb(1'b1, 8'h00, 32'h3d);
		watch(20);
		for (int c = 0; c < 4; c++)
			check(32'(t[c]), 32'(9 + c));
		check(32'(irq), 32'h4);
		apb(1'b1, 8'h18, 32'hf);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0);
		endt("four channels");
		// Gain channel paired with a plain neighbour, high impedance
		apb(1'b1, 8'h0c, 32'h01);
		apb(1'b1, 8'h00, 32'h0d);
		watch(20);
		check(32'(t[1]), 32'd9);
		check(32'(t[0]), 32'd10);
		check(32'(shd), 32'd0);
		endt("pair");
		// Every compare mode on ch2, which is above the threshold
		apb(1'b1, 8'h10, 32'h800);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 8'h18, 32'hf);
			apb(1'b1, 8'h0c, 32'(m) << 12);
			apb(1'b1, 8'h00, 32'h11);
			watch(20);
			check(32'(t[2] != 0), 32'(m != 1));
		end
		endt("compare");
		// Results drain the requests; ch1 alone drives the grouped line 0 request in each grouping
		for (int c = 0; c < 4; c++) begin
			apb(1'b0, 8'(32 + 4 * c), 32'h0);
			check(rd, 32'(ain[c]));
		end
		@(posedge clk);
		check(32'(dma_req), 32'h0);
		for (int g = 1; g < 4; g++) begin
			apb(1'b1, 8'h00, 32'h09 | (32'(g) << 6));
			watch(15);
			check(32'(dma_req), 32'h1);
			apb(1'b0, 8'h24, 32'h0);
			@(posedge clk);
			check(32'(dma_req), 32'h0);
		end
		endt("dma");
		// Flush by event with ch0 in flight; ch1 starts on the flush
		apb(1'b1, 8'h04, 32'h90);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b1, 8'h00, 32'h05);
		repeat (15) @(posedge clk);
		apb(1'b1, 8'h08, 32'h12);
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		@(posedge clk);
		watch(90);
		check(32'(t[1]), 32'd72);
		check(32'(t[0]), 32'd0);
		// Software flush written together with a pending start
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h05);
		repeat (15) @(posedge clk);
		apb(1'b1, 8'h00, 32'h0b);
		watch(90);
		check(32'(t[1]), 32'd72);
		check(32'(t[0]), 32'd0);
		endt("flush");
		// Free running sweep over all channels from one start
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h60);
		apb(1'b1, 8'h00, 32'h13d);
		watch(60);
		check(32'(p0 >= 2 && t[3] != 0), 32'd1);
		apb(1'b1, 8'h00, 32'h02);
		endt("free run");
		close_out;
	end
endmodule
